//--- rtl/sac_pkg.sv
// Package for the conversion control block: offsets, fields, timing
package sac_pkg;
  // Register offsets
  localparam logic [2:0] OFS_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
  localparam logic [2:0] OFS_RESULT_LOW = 3'h2;
  localparam logic [2:0] OFS_CLOCK_CONFIG = 3'h3;
  localparam logic [2:0] OFS_CONTROL2 = 3'h4;
  // Status and control fields
  localparam int FLD_COMPLETE = 7;
  localparam int FLD_IRQ_EN = 6;
  localparam int FLD_CONTINUOUS = 5;
  localparam int FLD_CHANNEL_LSB = 0;
  localparam int CHANNEL_WIDTH = 5;
  // Clock config fields
  localparam int FLD_LOW_POWER = 7;
  localparam int FLD_DIV_LSB = 5;
  localparam int FLD_LONG_SAMPLE = 4;
  localparam int FLD_MODE_LSB = 2;
  localparam int FLD_INPUT_CLK = 0;
  // Control2 fields
  localparam int FLD_ASYNC_SEL = 1;
  localparam int FLD_HW_TRIG = 0;
  // Reset values and full scale codes
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h1f;
  localparam logic [7:0] RST_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] RST_CONTROL2 = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [9:0] FULL_SCALE_10 = 10'h3ff;
  localparam logic [9:0] FULL_SCALE_8 = 10'h0ff;
  // Mode codes
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h1;
  // Timing: conversion lengths in converter clocks, first conversion (subsequent is two less); sync in system clocks, startup in ns
  localparam logic [5:0] CYC_8_SHORT = 6'd18;
  localparam logic [5:0] CYC_8_LONG = 6'd38;
  localparam logic [5:0] CYC_10_SHORT = 6'd21;
  localparam logic [5:0] CYC_10_LONG = 6'd41;
  localparam logic [5:0] CYC_FIRST_EXTRA = 6'd2;
  localparam logic [1:0] BUS_SYNC_CYCLES = 2'd3;
  localparam int ASYNC_STARTUP_NS = 5000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ASYNC_STARTUP_CYC = (ASYNC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock source selection
  typedef enum logic [1:0] {SRC_ALT, SRC_BUS, SRC_ASYNC} sac_src_t;
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sac_bus_t;
  // Analog core handshake
  typedef struct packed {
    logic [CHANNEL_WIDTH-1:0] channel;
    logic sample_long;
  } sac_core_t;
endpackage

//--- rtl/sac_ctrl.sv
// Conversion control for a 10-bit successive approximation converter
// Summary of operation
// - Input at or above upper reference gives all ones; at or below lower gives zero.
// - Ten-bit result spans high and low; eight-bit result is rounded into low.
// - Completion is the result transfer; complete flag sets at that transfer.
// - Interrupt raised only if irq enable is high when complete flag sets.
// - Async select picks async clock; else input select picks bus or alternate.
// - Async clock runs only while converting with it; speed follows low power bit.
// - Selected clock is divided by 1, 2, 4 or 8 for converter clock.
// - One input converted at a time, chosen by channel select field.
// - Ten or eight bit mode; long sample and continuous options supported.
// - Write to status control with channel not all ones starts conversion.
// - Hardware trigger select bit is not kept; control2 stores only the async select bit.
// - No hardware trigger exists here; trigger path tied inactive.
// - Continuous mode restarts after each transfer until aborted.
// - Ten-bit mode, high read but low not: transfer blocked, flag not set.
// - A blocked transfer always starts another conversion.
// - Abort on status write, clock config write, reset, or stop without async.
// - Abort keeps last result; reset returns results to reset values.
// - After reset, or an abort that is not also a start, enter inactive low power state at once.
// - Eight-bit short sample: 18 converter clocks first, 16 later.
// - Eight-bit long sample: 38 converter clocks first, 36 later.
// - Ten-bit short sample: 21 converter clocks first, 19 later.
// - Ten-bit long sample: 41 converter clocks first, 39 later.
// - Complete flag sets at every conversion end not blocked, regardless of irq enable.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_stop_mode,
  input wire logic i_clk_alt,
  input wire logic i_clk_async,
  input wire logic [9:0] i_core_result,
  output logic o_irq,
  output logic o_converting,
  output logic o_async_clk_en,
  output logic o_async_low_power,
  output logic o_converter_clock,
  output logic [1:0] o_clk_src,
  output logic [4:0] o_mux_channel,
  output logic o_sample_long
);

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_CONVERT} sac_state_t;

  sac_state_t state;
  logic [7:0] status_control;
  logic [7:0] clock_config;
  logic [7:0] control2;
  logic [9:0] result;
  logic high_read;
  logic first_conv;
  logic [5:0] converter_clock_count;
  logic [9:0] sync_count;
  logic [2:0] div_count;
  logic [2:0] div_mask;
  logic alt_s1, alt_s2, alt_s3;
  logic asy_s1, asy_s2, asy_s3;
  logic stop_s1, stop_s2;
  logic src_level;
  logic src_rise;
  logic converter_clock_tick;
  logic hw_trigger;
  logic start_sw;
  logic abort;
  logic done;
  logic blocked;
  logic is_10bit;
  logic [9:0] rounded;
  sac_bus_t bus;
  sac_core_t core;
  sac_src_t src;

  // Conversion length in converter clocks
  function automatic logic [5:0] conv_cycles(input logic ten, input logic lng, input logic first);
    logic [5:0] c;
    c = ten ? (lng ? CYC_10_LONG : CYC_10_SHORT) : (lng ? CYC_8_LONG : CYC_8_SHORT);
    return first ? c : c - CYC_FIRST_EXTRA;
  endfunction

  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
  assign core = '{channel: status_control[FLD_CHANNEL_LSB +: CHANNEL_WIDTH],
    sample_long: clock_config[FLD_LONG_SAMPLE]};
  assign hw_trigger = 1'b0;
  assign is_10bit = clock_config[FLD_MODE_LSB +: 2] == MODE_10BIT;
  assign start_sw = bus.wr && bus.addr == OFS_STATUS_CONTROL
    && bus.wdata[FLD_CHANNEL_LSB +: CHANNEL_WIDTH] != '1;
  // Abort sources
  assign abort = (bus.wr && (bus.addr == OFS_STATUS_CONTROL || bus.addr == OFS_CLOCK_CONFIG))
    || (stop_s2 && !control2[FLD_ASYNC_SEL]);
  assign done = state == ST_CONVERT && converter_clock_tick && converter_clock_count == 6'd1 && !abort;
  assign blocked = done && is_10bit && high_read;
  // Clamp and round to 8 bits in 8-bit mode
  assign rounded = is_10bit ? i_core_result
    : (i_core_result[9:2] == 8'hff ? FULL_SCALE_8
    : {2'b00, i_core_result[9:2] + {7'h00, i_core_result[1]}});

  // Clock source decode
  always_comb
  begin
    if (control2[FLD_ASYNC_SEL])
      src = SRC_ASYNC;
    else if (clock_config[FLD_INPUT_CLK])
      src = SRC_BUS;
    else
      src = SRC_ALT;
  end

  // Source edge detection on synchronised clocks; bus source ticks every cycle
  always_comb
  begin
    unique case (src)
      SRC_ASYNC: src_rise = asy_s2 && !asy_s3;
      SRC_ALT: src_rise = alt_s2 && !alt_s3;
      SRC_BUS: src_rise = 1'b1;
      default: src_rise = 1'b0;
    endcase
    src_level = src_rise;
  end

  // Divider tick
  always_comb
  begin
    div_mask = 3'((4'h1 << clock_config[FLD_DIV_LSB +: 2]) - 4'h1);
    converter_clock_tick = src_level && (div_count & div_mask) == div_mask;
  end

  // Alternate clock synchroniser and edge stage
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      alt_s1 <= 1'b0;
      alt_s2 <= 1'b0;
      alt_s3 <= 1'b0;
    end
    else
    begin
      alt_s1 <= i_clk_alt;
      alt_s2 <= alt_s1;
      alt_s3 <= alt_s2;
    end
  end

  // Async clock synchroniser and edge stage
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      asy_s1 <= 1'b0;
      asy_s2 <= 1'b0;
      asy_s3 <= 1'b0;
    end
    else
    begin
      asy_s1 <= i_clk_async;
      asy_s2 <= asy_s1;
      asy_s3 <= asy_s2;
    end
  end

  // Stop mode synchroniser
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stop_s1 <= 1'b0;
      stop_s2 <= 1'b0;
    end
    else
    begin
      stop_s1 <= i_stop_mode;
      stop_s2 <= stop_s1;
    end
  end

  // Divider counter
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      div_count <= 3'h0;
    else if (state != ST_CONVERT)
      div_count <= 3'h0;
    else if (src_level)
      div_count <= div_count + 3'h1;
  end

  // Registers written by software
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      status_control <= RST_STATUS_CONTROL;
      clock_config <= RST_CLOCK_CONFIG;
      control2 <= RST_CONTROL2;
    end
    else
    begin
      if (bus.wr && bus.addr == OFS_CLOCK_CONFIG)
        clock_config <= bus.wdata;
      if (bus.wr && bus.addr == OFS_CONTROL2)
        control2 <= bus.wdata & 8'h02;
      if (bus.wr && bus.addr == OFS_STATUS_CONTROL)
        status_control[6:0] <= bus.wdata[6:0];
      // Set wins over clear
      if (done && !blocked)
        status_control[FLD_COMPLETE] <= 1'b1;
      else if (bus.wr && bus.addr == OFS_STATUS_CONTROL)
        status_control[FLD_COMPLETE] <= 1'b0;
      else if (bus.rd && bus.addr == OFS_RESULT_LOW)
        status_control[FLD_COMPLETE] <= 1'b0;
    end
  end

  // Result registers and read tracking
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      result <= RST_RESULT;
      high_read <= 1'b0;
    end
    else
    begin
      if (done && !blocked)
        result <= rounded;
      if (bus.rd && bus.addr == OFS_RESULT_HIGH)
        high_read <= 1'b1;
      else if (bus.rd && bus.addr == OFS_RESULT_LOW)
        high_read <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      converter_clock_count <= 6'h0;
      sync_count <= 10'h0;
      first_conv <= 1'b1;
    end
    else if (abort)
    begin
      state <= start_sw ? ST_SYNC : ST_IDLE;
      first_conv <= 1'b1;
      sync_count <= control2[FLD_ASYNC_SEL] && bus.addr == OFS_STATUS_CONTROL
        ? 10'(ASYNC_STARTUP_CYC) + 10'(BUS_SYNC_CYCLES) : 10'(BUS_SYNC_CYCLES);
    end
    else if (hw_trigger && state == ST_IDLE)
    begin
      state <= ST_SYNC;
      sync_count <= 10'(BUS_SYNC_CYCLES);
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          first_conv <= 1'b1;
        end
        ST_SYNC:
        begin
          if (sync_count <= 10'h1)
          begin
            state <= ST_CONVERT;
            converter_clock_count <= conv_cycles(is_10bit, clock_config[FLD_LONG_SAMPLE], first_conv);
          end
          else
            sync_count <= sync_count - 10'h1;
        end
        ST_CONVERT:
        begin
          if (done)
          begin
            first_conv <= 1'b0;
            if (blocked || status_control[FLD_CONTINUOUS])
              converter_clock_count <= conv_cycles(is_10bit, clock_config[FLD_LONG_SAMPLE], 1'b0);
            else
              state <= ST_IDLE;
          end
          else if (converter_clock_tick)
            converter_clock_count <= converter_clock_count - 6'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Completion interrupt pulse
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= done && !blocked && status_control[FLD_IRQ_EN];
  end

  // Run status towards the analog side
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_converting <= 1'b0;
      o_async_clk_en <= 1'b0;
      o_converter_clock <= 1'b0;
    end
    else
    begin
      o_converting <= state != ST_IDLE && !abort;
      o_async_clk_en <= state != ST_IDLE && !abort && control2[FLD_ASYNC_SEL];
      o_converter_clock <= state == ST_CONVERT && converter_clock_tick && !abort;
    end
  end

  // Configuration mirrors
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_async_low_power <= 1'b0;
      o_clk_src <= 2'h0;
      o_mux_channel <= RST_STATUS_CONTROL[4:0];
      o_sample_long <= 1'b0;
    end
    else
    begin
      o_async_low_power <= clock_config[FLD_LOW_POWER];
      o_clk_src <= 2'(src);
      o_mux_channel <= core.channel;
      o_sample_long <= core.sample_long;
    end
  end

  // Read data, standing one cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        OFS_STATUS_CONTROL: o_rdata <= status_control;
        OFS_RESULT_HIGH: o_rdata <= {6'h00, result[9:8]};
        OFS_RESULT_LOW: o_rdata <= result[7:0];
        OFS_CLOCK_CONFIG: o_rdata <= clock_config;
        OFS_CONTROL2: o_rdata <= control2;
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

//--- bench/sac_core_model.sv
// Analog core and clock sources facing the conversion control
`timescale 1ns/1ps
`default_nettype none
module sac_core_model
  import sac_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_async_en,
  input wire logic [4:0] i_channel,
  output logic o_clk_alt,
  output logic o_clk_async,
  output logic [9:0] o_result
);
  logic [2:0] div_cnt = 3'h0;
  always_ff @(posedge i_clk_sys)
  begin
    div_cnt <= div_cnt + 3'h1;
  end
  assign o_clk_alt = div_cnt[1];
  // Oscillator stands low unless requested
  assign o_clk_async = i_async_en & div_cnt[2];
  // Full scale, zero scale, else a channel pattern
  assign o_result = (i_channel == 5'h1e) ? 10'h3ff :
    (i_channel == 5'h1d) ? 10'h000 : {i_channel, i_channel};
endmodule
`default_nettype wire

//--- bench/sac_ctrl_asserts.sv
// Port checker for the conversion control
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_asserts
  import sac_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_stop_mode,
  input wire logic o_irq,
  input wire logic o_converting,
  input wire logic o_async_clk_en,
  input wire logic o_async_low_power,
  input wire logic o_converter_clock,
  input wire logic [1:0] o_clk_src,
  input wire logic [4:0] o_mux_channel,
  input wire logic o_sample_long
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_stat_wr;
    i_wr && i_addr == OFS_STATUS_CONTROL;
  endsequence
  sequence s_cfg_wr;
    i_wr && i_addr == OFS_CLOCK_CONFIG;
  endsequence
  property p_channel;
    s_stat_wr |-> ##2 o_mux_channel == $past(i_wdata[4:0], 2);
  endproperty
  a_channel: assert property (p_channel) else $error("channel not taken");
  property p_start;
    s_stat_wr ##0 i_wdata[4:0] != 5'h1f |-> ##2 o_converting;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_idle_ch;
    s_stat_wr ##0 i_wdata[4:0] == 5'h1f |-> ##2 !o_converting;
  endproperty
  a_idle_ch: assert property (p_idle_ch) else $error("no abort");
  property p_cfg_abort;
    s_cfg_wr |-> ##2 !o_converting;
  endproperty
  a_cfg_abort: assert property (p_cfg_abort) else $error("config no abort");
  property p_cfg_bits;
    s_cfg_wr |-> ##2 o_sample_long == $past(i_wdata[FLD_LONG_SAMPLE], 2)
      && o_async_low_power == $past(i_wdata[FLD_LOW_POWER], 2);
  endproperty
  a_cfg_bits: assert property (p_cfg_bits) else $error("config bits");
  property p_src;
    i_wr && i_addr == OFS_CONTROL2 && i_wdata[FLD_ASYNC_SEL] |-> ##2 o_clk_src == SRC_ASYNC;
  endproperty
  a_src: assert property (p_src) else $error("source not async");
  property p_irq;
    o_irq |-> $past(o_converting) ##1 !o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq pulse");
  property p_tick;
    o_converter_clock |-> o_converting;
  endproperty
  a_tick: assert property (p_tick) else $error("tick when idle");
  property p_stop;
    $rose(i_stop_mode) && !o_async_clk_en |-> ##[1:5] !o_converting;
  endproperty
  a_stop: assert property (p_stop) else $error("stop no abort");
  property p_async_run;
    o_async_clk_en |-> o_clk_src == SRC_ASYNC && (o_converting || $past(o_converting));
  endproperty
  a_async_run: assert property (p_async_run) else $error("osc runs idle");
endmodule
`default_nettype wire

//--- bench/sac_ctrl_test.sv
// Testbench for the conversion control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module sac_ctrl_test;
  import sac_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, stop = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic irq, conv, aclk_en, alp, cclk, slong, calt, casy;
  logic [1:0] src;
  logic [4:0] chan;
  logic [9:0] core_res;
  int bad_count = 0, tests_run = 0, n, g;
  logic [9:0] exp10 [3] = '{10'h39c, 10'h3ff, 10'h000};
  logic [7:0] exp8 [3] = '{8'h19, 8'hff, 8'h00};
  logic [4:0] chs10 [3] = '{5'h1c, 5'h1e, 5'h1d};
  logic [4:0] chs8 [3] = '{5'h03, 5'h1e, 5'h1d};
  always #4 clk = ~clk;
  sac_ctrl dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .i_stop_mode(stop), .i_clk_alt(calt),
    .i_clk_async(casy), .i_core_result(core_res), .o_irq(irq), .o_converting(conv),
    .o_async_clk_en(aclk_en), .o_async_low_power(alp), .o_converter_clock(cclk),
    .o_clk_src(src), .o_mux_channel(chan), .o_sample_long(slong));
  sac_core_model core_u (.i_clk_sys(clk), .i_async_en(aclk_en), .i_channel(chan),
    .o_clk_alt(calt), .o_clk_async(casy), .o_result(core_res));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    @(negedge clk);
    while (irq !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wait_tick();
    g = 0;
    @(negedge clk);
    while (cclk !== 1'b1 && g < 100)
    begin
      @(negedge clk);
      g++;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_STATUS_CONTROL, RST_STATUS_CONTROL);
    rd(OFS_CLOCK_CONFIG, RST_CLOCK_CONFIG);
    rd(3'h5, 8'h00);
    wr(OFS_CLOCK_CONFIG, 8'h04);
    repeat (2) @(negedge clk);
    `CHK(src, SRC_ALT)
    wr(OFS_CLOCK_CONFIG, 8'h05);
    repeat (2) @(negedge clk);
    `CHK(src, SRC_BUS)
    $display("end of reset and source test");
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_STATUS_CONTROL, {3'b010, chs10[i]});
      wait_irq(60);
      `CHK(n < 28, 1'b1)
      rd(OFS_STATUS_CONTROL, {3'b110, chs10[i]});
      rd(OFS_RESULT_HIGH, {6'h00, exp10[i][9:8]});
      rd(OFS_RESULT_LOW, exp10[i][7:0]);
      rd(OFS_STATUS_CONTROL, {3'b010, chs10[i]});
    end
    wr(OFS_CLOCK_CONFIG, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_STATUS_CONTROL, {3'b010, chs8[i]});
      wait_irq(60);
      `CHK(n < 25, 1'b1)
      rd(OFS_RESULT_LOW, exp8[i]);
    end
    wr(OFS_STATUS_CONTROL, 8'h03);
    wait_irq(60);
    `CHK(n, 60)
    rd(OFS_STATUS_CONTROL, 8'h83);
    $display("end of conversion test");
    for (int d = 0; d < 4; d++)
    begin
      wr(OFS_CLOCK_CONFIG, 8'h05 | 8'(d << 5));
      wr(OFS_STATUS_CONTROL, 8'h1c);
      wait_tick();
      wait_tick();
      `CHK(g + 1, 1 << d)
      wr(OFS_STATUS_CONTROL, 8'h1f);
    end
    $display("end of divide test");
    wr(OFS_CLOCK_CONFIG, 8'h05);
    wr(OFS_STATUS_CONTROL, 8'h5c);
    wait_irq(60);
    rd(OFS_RESULT_HIGH, 8'h03);
    wr(OFS_STATUS_CONTROL, 8'h5c);
    wait_irq(100);
    `CHK(n, 100)
    `CHK(conv, 1'b1)
    rd(OFS_RESULT_LOW, 8'h9c);
    wait_irq(60);
    `CHK(n < 28, 1'b1)
    $display("end of blocking test");
    wr(OFS_CLOCK_CONFIG, 8'h14);
    wr(OFS_STATUS_CONTROL, 8'h5c);
    wait_irq(300);
    `CHK(n > 21 * 4 + 3 && n <= 41 * 4 + 3, 1'b1)
    rd(OFS_RESULT_LOW, 8'h9c);
    wr(OFS_CLOCK_CONFIG, 8'h05);
    $display("end of long sample test");
    wr(OFS_STATUS_CONTROL, 8'h7c);
    wait_irq(60);
    wait_irq(60);
    `CHK(n < 24, 1'b1)
    wr(OFS_STATUS_CONTROL, 8'h1f);
    repeat (3) @(negedge clk);
    `CHK(conv, 1'b0)
    rd(OFS_RESULT_LOW, 8'h9c);
    wr(OFS_STATUS_CONTROL, 8'h5c);
    repeat (8) @(posedge clk);
    stop <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(conv, 1'b0)
    @(posedge clk);
    stop <= 1'b0;
    $display("end of abort test");
    wr(OFS_CONTROL2, 8'h02);
    wr(OFS_CLOCK_CONFIG, 8'h85);
    repeat (2) @(negedge clk);
    `CHK(alp, 1'b1)
    `CHK(src, SRC_ASYNC)
    wr(OFS_STATUS_CONTROL, 8'h5e);
    repeat (4) @(negedge clk);
    `CHK(aclk_en, 1'b1)
    wait_irq(2000);
    `CHK(n < 2000, 1'b1)
    repeat (4) @(negedge clk);
    `CHK(aclk_en, 1'b0)
    rd(OFS_RESULT_LOW, 8'hff);
    wr(OFS_STATUS_CONTROL, 8'h5c);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(chan, 5'h1f)
    rd(OFS_RESULT_LOW, 8'h00);
    $display("end of async and reset test");
    wrap_up();
  end
endmodule
bind sac_ctrl sac_ctrl_asserts chk_u (.*);
`default_nettype wire
